/* File: logic/clock_ctrl_consts.vh */
// Constants for the clock source and failure control block.
// Assumes inclusion by bare name from design files under logic/.
`ifndef CLOCK_CTRL_CONSTS_VH
`define CLOCK_CTRL_CONSTS_VH
`define CLK_RATE_HZ        25000000
`define OPT_WORD_W         8
`define OPT_WORDS          4
`define OPT_ADDR_W         2
// Option word 0 field positions
`define OPT_OSC_MODE_LSB   0
`define OPT_OSC_MODE_MSB   1
`define OPT_XTAL_DIS_BIT   2
// Clock source select codes
`define SRC_IPO            3'h0
`define SRC_XTAL           3'h1
`define SRC_EXT            3'h2
`define SRC_WDT            3'h3
// Oscillator modes
`define MODE_XTAL_LOW      2'h0
`define MODE_XTAL_MED      2'h1
`define MODE_XTAL_HIGH     2'h2
`define MODE_RC            2'h3
// Watchdog oscillator failure: system cycles without a watchdog edge
`define WDT_FAIL_CYCLES    8004
// Primary failure threshold 1 kHz, expressed as a period in ns
`define PRI_FAIL_PERIOD_NS 1000000
`define PRI_FAIL_CYCLES    ((`PRI_FAIL_PERIOD_NS) / 40)
`endif

/* File: logic/clock_source_failure_control.v */
// Clock source selection, option loading and oscillator failure control.
// Assumes option memory answers in the same cycle as opt_rd_o with an address.
// Operation
// (RQ1) Every reset reloads option bits from program memory into hidden registers.
// (RQ2) Option memory changes take effect only after the next reset.
// (RQ3) Reset is held until option loading has finished.
// (RQ4) Option registers have no software read or write path.
// (RQ5) Software clears both failure enables before changing clock source.
// (RQ6) Failure enables may be set again after a source write completes.
// (RQ7) Precision oscillator runs after reset until software disables it.
// (RQ8) Primary failure raises event and switches system clock to watchdog osc.
// (RQ9) Switch only if watchdog oscillator enabled; watchdog reset not needed.
// (RQ10) Primary failure detected when clock falls below about 1 kHz.
// (RQ11) Watchdog oscillator failure raises event, clock source unchanged.
// (RQ12) After watchdog failure, primary failure is no longer detected.
// (RQ13) Software disables watchdog failure enable when that osc unusable.
// (RQ14) Watchdog failure declared after 8004 cycles without watchdog edge.
// (RQ15) System clock equals oscillator input, no internal divider.
// (RQ16) Oscillator mode comes from option bits, four modes.
// (RQ17) Crystal disable option sets crystal enable during reset; the core loads enable as the inverse of that bit.
// (RQ18) Software waits 1000 crystal cycles before selecting crystal.
// (RQ19) Primary detection best left off with slow external clocks.
// (RQ20) Each failure sets sticky status until software clears it.
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module clock_source_failure_control #(
  parameter WDT_FAIL_CYCLES = `WDT_FAIL_CYCLES,
  parameter PRI_FAIL_CYCLES = `PRI_FAIL_CYCLES
) (
  input  wire       ref_clk_i,
  input  wire       rst_i,
  // Option memory port
  output reg        opt_rd_o,
  output reg  [1:0] opt_addr_o,
  input  wire [7:0] opt_data_i,
  // Oscillator activity, asynchronous
  input  wire       sys_osc_activity_i,
  input  wire       wdt_osc_clk_i,
  // Software control, same clock
  input  wire       ctrl_we_i,
  input  wire [2:0] clock_source_select_i,
  input  wire       sys_osc_fail_enable_i,
  input  wire       wdt_fail_detect_enable_i,
  input  wire       ipo_enable_i,
  input  wire       xtal_enable_i,
  input  wire       wdt_osc_enable_i,
  input  wire       fail_clear_we_i,
  input  wire [1:0] fail_clear_i,
  // Outputs
  output reg        cpu_reset_o,
  output reg  [2:0] clock_source_o,
  output reg        ipo_enable_o,
  output reg        xtal_enable_o,
  output reg  [1:0] osc_mode_o,
  output reg        sys_osc_fail_event_o,
  output reg        wdt_osc_fail_event_o,
  output reg  [1:0] fail_status_o,
  output reg        sys_fail_en_o,
  output reg        wdt_fail_en_o
);
  localparam [2:0] ST_LOAD = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;
  localparam       CNT_W   = 16;
  localparam [CNT_W-1:0] WDT_LIM = WDT_FAIL_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] PRI_LIM = PRI_FAIL_CYCLES[CNT_W-1:0];

  reg [2:0]       state_reg;
  reg [7:0]       option_reg [0:`OPT_WORDS-1];
  reg [1:0]       load_idx_reg;
  reg [CNT_W-1:0] wdt_cnt_reg;
  reg [CNT_W-1:0] pri_cnt_reg;
  reg             wdt_dead_reg;
  wire            sys_rise;
  wire            wdt_rise;
  wire            sys_fail_hit;
  wire            wdt_fail_hit;

  edge_sync u_sys_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (sys_osc_activity_i),
    .rise_o    (sys_rise)
  );
  edge_sync u_wdt_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (wdt_osc_clk_i),
    .rise_o    (wdt_rise)
  );

  //////////////////////////////////////////////////////////////////////////
  // Option load: sequencer reads every word, then lets the core run
  // Option registers live only here; no port exposes a write path
  always @(posedge ref_clk_i) begin
    if (rst_i) begin // RQ1
      state_reg    <= ST_LOAD;
      load_idx_reg <= 2'h0;
      opt_rd_o     <= 1'b0;
      opt_addr_o   <= 2'h0;
      cpu_reset_o  <= 1'b1;
    end else begin
      opt_rd_o <= 1'b0;
      case (state_reg)
        ST_LOAD: begin
          opt_rd_o   <= 1'b1;
          opt_addr_o <= load_idx_reg;
          state_reg  <= ST_WAIT;
        end
        ST_WAIT: begin
          option_reg[load_idx_reg] <= opt_data_i; // RQ1 RQ2 RQ4
          if (load_idx_reg == 2'h3) begin
            state_reg   <= ST_RUN;
            cpu_reset_o <= 1'b0; // RQ3
          end else begin
            load_idx_reg <= load_idx_reg + 2'h1;
            state_reg    <= ST_LOAD;
          end
        end
        ST_RUN: begin
          cpu_reset_o <= 1'b0;
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Failure detectors; counts run only while enabled in the run state
  assign wdt_fail_hit = wdt_fail_en_o & ~wdt_dead_reg &
                        (wdt_cnt_reg == WDT_LIM - 16'h0001);
  // Slow-clock threshold seen from the reference clock; a slow but
  // valid external clock trips it, which is why software may leave it off
  assign sys_fail_hit = sys_fail_en_o & ~wdt_dead_reg &
                        (pri_cnt_reg == PRI_LIM - 16'h0001);

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wdt_cnt_reg <= 16'h0000;
      pri_cnt_reg <= 16'h0000;
    end else begin
      if (!wdt_fail_en_o || wdt_rise || wdt_fail_hit)
        wdt_cnt_reg <= 16'h0000;
      else
        wdt_cnt_reg <= wdt_cnt_reg + 16'h0001; // RQ14
      if (!sys_fail_en_o || sys_rise || sys_fail_hit)
        pri_cnt_reg <= 16'h0000;
      else
        pri_cnt_reg <= pri_cnt_reg + 16'h0001; // RQ10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control state, driven by software writes and by failures
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      clock_source_o       <= `SRC_IPO;
      ipo_enable_o         <= 1'b1; // RQ7
      xtal_enable_o        <= 1'b0;
      osc_mode_o           <= `MODE_XTAL_LOW;
      sys_fail_en_o        <= 1'b0;
      wdt_fail_en_o        <= 1'b0;
      sys_osc_fail_event_o <= 1'b0;
      wdt_osc_fail_event_o <= 1'b0;
      fail_status_o        <= 2'h0;
      wdt_dead_reg         <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      // Options take effect as reset leaves, never later
      osc_mode_o    <= option_reg[0][`OPT_OSC_MODE_MSB:`OPT_OSC_MODE_LSB];
      xtal_enable_o <= ~option_reg[0][`OPT_XTAL_DIS_BIT]; // RQ16 RQ17
    end else begin
      sys_osc_fail_event_o <= sys_fail_hit; // RQ8
      wdt_osc_fail_event_o <= wdt_fail_hit; // RQ11
      if (ctrl_we_i) begin
        // Clock passes straight from the chosen source, undivided
        clock_source_o <= clock_source_select_i; // RQ15
        sys_fail_en_o  <= sys_osc_fail_enable_i; // RQ6
        wdt_fail_en_o  <= wdt_fail_detect_enable_i; // RQ6
        ipo_enable_o   <= ipo_enable_i; // RQ7
        xtal_enable_o  <= xtal_enable_i;
      end
      if (sys_fail_hit && wdt_osc_enable_i)
        clock_source_o <= `SRC_WDT; // RQ8 RQ9
      if (wdt_fail_hit)
        wdt_dead_reg <= 1'b1; // RQ12
      // Set wins over a clear in the same cycle
      fail_status_o <= ((fail_clear_we_i ? fail_status_o & ~fail_clear_i
                                         : fail_status_o)
                        | {wdt_fail_hit, sys_fail_hit}); // RQ20
    end
  end
endmodule // clock_source_failure_control

/* File: logic/edge_sync.v */
// Three-stage synchroniser with rising-edge pulse for an oscillator pin.
// Assumes one ref_clk_i domain; input is asynchronous.
`timescale 1ns/1ps
module edge_sync (
  input  wire ref_clk_i,
  input  wire rst_i,
  input  wire async_i,
  output reg  rise_o
);
  reg [2:0] sync_reg;
  reg       level_reg;
  // Stage 1 may be metastable; a level counts once stages 2 and 3 agree.
  // Costs a cycle of latency; the pin must hold each level two cycles
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
      rise_o    <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], async_i};
      rise_o   <= (sync_reg[1] == sync_reg[2]) & sync_reg[2] & ~level_reg;
      if (sync_reg[1] == sync_reg[2])
        level_reg <= sync_reg[2];
    end
  end
endmodule // edge_sync

/* File: sim/clock_source_failure_control_bench.sv */
// Self-checking bench for the clock control core.
// Assumes the partner model answers option reads; short fail counts.
`timescale 1ns/1ps
module clock_source_failure_control_bench;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, ctrl_we_i = 1'h0, hit;
  logic fail_clear_we_i = 1'h0, ipo_enable_i = 1'h1, xtal_enable_i = 1'h0;
  logic sys_osc_fail_enable_i = 1'h0, wdt_fail_detect_enable_i = 1'h0;
  logic wdt_osc_enable_i = 1'h1, pri_run = 1'h1, wdt_run = 1'h1;
  logic [2:0] clock_source_select_i = 3'h0;
  logic [1:0] fail_clear_i = 2'h0;
  logic [7:0] word0 = 8'h00;
  wire [7:0] opt_data_i;
  wire [2:0] clock_source_o;
  wire [1:0] opt_addr_o, osc_mode_o, fail_status_o;
  wire opt_rd_o, cpu_reset_o, ipo_enable_o, xtal_enable_o, sys_osc_activity_i;
  wire sys_osc_fail_event_o, wdt_osc_fail_event_o, sys_fail_en_o;
  wire wdt_fail_en_o, wdt_osc_clk_i;
  int n_fail = 0, checked = 0;
  // Option word, then expected mode and crystal enable
  logic [10:0] rows [4] = '{{8'h00, 2'h0, 1'h1}, {8'h05, 2'h1, 1'h0},
                            {8'h02, 2'h2, 1'h1}, {8'hff, 2'h3, 1'h0}};
  clock_source_failure_control #(.WDT_FAIL_CYCLES(20), .PRI_FAIL_CYCLES(20))
    dut (.*);
  osc_partner model (.*);
  initial forever #20 ref_clk_i = ~ref_clk_i;
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reset_dut;
    rst_i = 1'h1;
    repeat (8) @(negedge ref_clk_i);
    rst_i = 1'h0;
    @(negedge ref_clk_i);
    chk(cpu_reset_o, 8'h1);
    repeat (20) if (cpu_reset_o !== 1'h0) @(negedge ref_clk_i);
  endtask
  task automatic ctrl(input logic [2:0] s, input logic so, wd, ip, xt);
    @(negedge ref_clk_i);
    {clock_source_select_i, sys_osc_fail_enable_i, wdt_fail_detect_enable_i,
     ipo_enable_i, xtal_enable_i, ctrl_we_i} = {s, so, wd, ip, xt, 1'h1};
    @(negedge ref_clk_i);
    ctrl_we_i = 1'h0;
  endtask
  // Events are one-cycle pulses, so the wait latches them
  task automatic wait_ev(input logic w, output logic got);
    got = 1'h0;
    repeat (60) begin
      @(negedge ref_clk_i);
      if ((w ? wdt_osc_fail_event_o : sys_osc_fail_event_o) === 1'h1) got = 1'h1;
    end
  endtask
  task automatic stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_fail++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      word0 = rows[i][10:3];
      reset_dut();
      chk(osc_mode_o, rows[i][2:1]);
      chk(xtal_enable_o, rows[i][0]);
      chk({clock_source_o, ipo_enable_o}, 8'h1);
    end
    word0 = 8'h00;
    repeat (10) @(negedge ref_clk_i);
    chk(osc_mode_o, 8'h3);
    reset_dut();
    chk({osc_mode_o, xtal_enable_o}, 8'h1);
    ctrl(3'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    chk({clock_source_o, ipo_enable_o, xtal_enable_o}, 8'h07);
    ctrl(3'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    chk({sys_fail_en_o, wdt_fail_en_o}, 8'h2);
    pri_run = 1'h0;
    wait_ev(1'h0, hit);
    chk({hit, clock_source_o, fail_status_o}, 8'h2d);
    pri_run = 1'h1;
    repeat (5) @(negedge ref_clk_i);
    fail_clear_i = 2'h1;
    fail_clear_we_i = 1'h1;
    @(negedge ref_clk_i);
    fail_clear_we_i = 1'h0;
    chk(fail_status_o, 8'h0);
    reset_dut();
    wdt_osc_enable_i = 1'h0;
    ctrl(3'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    ctrl(3'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    pri_run = 1'h0;
    wait_ev(1'h0, hit);
    chk({hit, clock_source_o, fail_status_o}, 8'h25);
    pri_run = 1'h1;
    wdt_run = 1'h0;
    ctrl(3'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    wdt_osc_enable_i = 1'h1;
    ctrl(3'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    wait_ev(1'h1, hit);
    chk({hit, clock_source_o, fail_status_o[1]}, 8'h13);
    ctrl(3'h1, 1'h1, 1'h1, 1'h1, 1'h1);
    pri_run = 1'h0;
    wait_ev(1'h0, hit);
    chk(hit, 8'h0);
    stop_test();
  end
endmodule // clock_source_failure_control_bench

/* File: sim/clock_source_failure_control_chk.sv */
// Port assertions for the clock control core.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/1ps
module clock_source_failure_control_chk #(
  parameter WDT_FAIL_CYCLES = 20,
  parameter PRI_FAIL_CYCLES = 20
) (
  input ref_clk_i, rst_i, opt_rd_o, ctrl_we_i, fail_clear_we_i,
  input [1:0] opt_addr_o, fail_clear_i, osc_mode_o, fail_status_o,
  input [7:0] opt_data_i,
  input sys_osc_activity_i, wdt_osc_clk_i, sys_osc_fail_enable_i,
  input wdt_fail_detect_enable_i, ipo_enable_i, xtal_enable_i,
  input wdt_osc_enable_i, cpu_reset_o, ipo_enable_o, xtal_enable_o,
  input [2:0] clock_source_select_i, clock_source_o,
  input sys_osc_fail_event_o, wdt_osc_fail_event_o, sys_fail_en_o,
  input wdt_fail_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////
  a_load_hold: assert property ($fell(rst_i) |-> cpu_reset_o[*7])
    else $error("core left reset early");
  a_load_done: assert property ($fell(rst_i) |-> ##[1:12] !cpu_reset_o)
    else $error("option load too long");
  a_load_once: assert property (opt_rd_o |-> cpu_reset_o)
    else $error("option read after reset");
  a_load_order: assert property ($fell(rst_i) |=>
    opt_rd_o && opt_addr_o == 2'h0 ##6 opt_rd_o && opt_addr_o == 2'h3)
    else $error("option words read out of order");
  a_pri_switch: assert property (
    sys_osc_fail_event_o && wdt_osc_enable_i |-> ##[0:1] clock_source_o == 3'h3)
    else $error("no switch to watchdog clock");
  a_no_wdt_src: assert property (
    clock_source_o != 3'h3 && !wdt_osc_enable_i && !ctrl_we_i
    |=> clock_source_o != 3'h3) else $error("switch with osc off");
  a_src_cause: assert property (!$stable(clock_source_o) |->
    $past(ctrl_we_i) || sys_osc_fail_event_o || $past(sys_osc_fail_event_o))
    else $error("source changed without cause");
  a_pri_pulse: assert property (sys_osc_fail_event_o |=>
    !sys_osc_fail_event_o && fail_status_o[0]) else $error("bad primary event");
  a_pri_needs_en: assert property (sys_osc_fail_event_o |->
    sys_fail_en_o || $past(sys_fail_en_o)) else $error("primary event disabled");
  a_wdt_needs_en: assert property (wdt_osc_fail_event_o |->
    wdt_fail_en_o || $past(wdt_fail_en_o)) else $error("watchdog event disabled");
  a_no_pri_late: assert property (
    wdt_osc_fail_event_o |=> !sys_osc_fail_event_o[*8])
    else $error("primary detected after watchdog loss");
endmodule // clock_source_failure_control_chk
bind clock_source_failure_control clock_source_failure_control_chk #(
  .WDT_FAIL_CYCLES(WDT_FAIL_CYCLES), .PRI_FAIL_CYCLES(PRI_FAIL_CYCLES)) u_chk (.*);

/* File: sim/osc_partner.sv */
// Far side: option memory and the two oscillators.
// Assumes option reads must stand by the next rising clock edge.
`timescale 1ns/1ps
module osc_partner (
  input              ref_clk_i,
  input              opt_rd_o,
  input        [1:0] opt_addr_o,
  input        [7:0] word0,
  input              pri_run,
  input              wdt_run,
  output logic [7:0] opt_data_i = 8'h5a,
  output logic       sys_osc_activity_i = 1'h0,
  output logic       wdt_osc_clk_i = 1'h0
);
  logic ph = 1'h0;
  // Answer from the falling edge so the word stands at the rising edge;
  // the bus flips outside an answer so a stale byte never matches
  always @(negedge ref_clk_i)
    opt_data_i <= opt_rd_o ? (opt_addr_o == 2'h0 ? word0 : 8'h00)
                           : ~opt_data_i;
  // Each level held two cycles, the shortest the pin filter accepts
  always @(posedge ref_clk_i) begin
    ph <= ~ph;
    if (ph) begin
      sys_osc_activity_i <= sys_osc_activity_i ^ pri_run;
      wdt_osc_clk_i <= wdt_osc_clk_i ^ wdt_run;
    end
  end
endmodule // osc_partner
